// File: hw/buck_voltage_phase_control.sv
// Digital control for two step-down regulators: trim, modes, shedding,
// voltage choice and ramps. Assumes pins are asynchronous to ref_clk_i.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module buck_voltage_phase_control
    import buck_ctrl_pkg::*;
#(
    parameter int MAX_PHASES = 4,
    parameter int GPI_COUNT  = 4
) (
    // Clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_n_i,
    // Register port
    input  wire logic [8:0]           addr_i,
    input  wire logic [31:0]          wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic      [31:0]          rdata_o,
    // Write protect pin
    input  wire logic                 volt_lock_i,
    // General inputs and tracking value
    input  wire logic [GPI_COUNT-1:0] general_input_i,
    input  wire logic [7:0]           track_volt_i,
    // Analog side
    input  wire logic [1:0]           high_load_i,
    input  wire logic [1:0]           current_limit_i,
    output logic      [5:0]           osc_freq_trim_o,
    output reg_stat_type              stat_a_o,
    output reg_stat_type              stat_b_o,
    output logic      [1:0]           overcurrent_event_o,
    output logic                      input0_change_o
);

    if (MAX_PHASES != 2 && MAX_PHASES != 4) begin : bad_phases_g
        $error("MAX_PHASES must be 2 or 4");
    end
    if (GPI_COUNT < 1 || GPI_COUNT > 4) begin : bad_gpi_g
        $error("GPI_COUNT must be 1 to 4");
    end

    // =========================================================
    // Helpers
    // =========================================================
    function automatic logic [7:0] clamp_volt(logic [7:0] v, logic [7:0] m);
        return (v > m) ? m : v;
    endfunction

    function automatic logic [7:0] step_cycles(logic [1:0] rate);
        return 8'(STEP_CYC_FAST) << (2'h3 - rate);
    endfunction

    function automatic logic [2:0] phase_count(logic shed, logic hi,
                                               logic [1:0] cap);
        logic [2:0] full;
        logic [2:0] lim;
        full = 3'(MAX_PHASES);
        lim  = 3'(cap) + 3'h1;
        if (shed && !hi)
            full = 3'h1;
        return (full > lim) ? lim : full;
    endfunction

    // =========================================================
    // Pin synchronisers, three stages
    // =========================================================
    localparam int SW = GPI_COUNT + 10;
    logic [SW-1:0] s1_reg, s2_reg, s3_reg, pin_raw, pin_prev_reg;
    logic [SW-1:0] pin_now_reg, pin_now_next;
    logic [GPI_COUNT-1:0] gpi, gpi_edge;
    logic [7:0] track_v;
    logic [1:0] hi_load, lim_hit;
    logic       lock;

    assign pin_raw = {volt_lock_i, current_limit_i, high_load_i,
                      track_volt_i[4:0], general_input_i};

    always_comb begin
        pin_now_next = pin_now_reg;
        for (int i = 0; i < SW; i++)
            if (s2_reg[i] == s3_reg[i])
                pin_now_next[i] = s3_reg[i];
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg       <= '0;
            s2_reg       <= '0;
            s3_reg       <= '0;
            pin_now_reg  <= '0;
            pin_prev_reg <= '0;
        end else begin
            s1_reg       <= pin_raw;
            s2_reg       <= s1_reg;
            s3_reg       <= s2_reg;
            pin_now_reg  <= pin_now_next;
            pin_prev_reg <= pin_now_reg;
        end
    end

    assign gpi      = pin_now_reg[GPI_COUNT-1:0];
    assign gpi_edge = gpi ^ pin_prev_reg[GPI_COUNT-1:0];
    assign track_v  = {3'h0, pin_now_reg[GPI_COUNT+4:GPI_COUNT]};
    assign hi_load  = pin_now_reg[GPI_COUNT+6:GPI_COUNT+5];
    assign lim_hit  = pin_now_reg[GPI_COUNT+8:GPI_COUNT+7];
    assign lock     = pin_now_reg[GPI_COUNT+9];

    // =========================================================
    // Register file
    // =========================================================
    reg_cfg_type cfg_reg [2], cfg_next [2];
    logic [7:0]  vpri_reg [2], vpri_next [2], valt_reg [2], valt_next [2];
    logic [7:0]  vmax_reg [2], vmax_next [2];
    logic [5:0]  trim_reg, trim_next;
    logic        track_on_reg, track_on_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  retarget;
    logic        wr_ok;
    reg_stat_type stat [2];

    assign wr_ok = wr_i && !(lock && addr_i >= ADDR_PROT_LO
                             && addr_i <= ADDR_PROT_HI);

    always_comb begin
        cfg_next      = cfg_reg;
        vpri_next     = vpri_reg;
        valt_next     = valt_reg;
        vmax_next     = vmax_reg;
        trim_next     = trim_reg;
        track_on_next = track_on_reg;
        retarget      = 2'b00;
        rdata_next    = 32'h0000_0000;
        if (wr_ok) begin
            if (addr_i == ADDR_OSC) begin
                trim_next = wdata_i[5:0];
            end else if (addr_i == ADDR_INPUT0) begin
                track_on_next = wdata_i[0];
            end else begin
                for (int r = 0; r < 2; r++) begin
                    if (addr_i == ADDR_CFG_A + 9'(r * 16)) begin
                        cfg_next[r] = reg_cfg_type'(wdata_i[22:0]);
                        if (cfg_next[r].volt_choose != cfg_reg[r].volt_choose)
                            retarget[r] = 1'b1;
                    end else if (addr_i == ADDR_VPRI_A + 9'(r * 16)) begin
                        vpri_next[r] = wdata_i[7:0];
                        retarget[r]  = !cfg_reg[r].volt_choose;
                    end else if (addr_i == ADDR_VALT_A + 9'(r * 16)) begin
                        valt_next[r] = wdata_i[7:0];
                        retarget[r]  = cfg_reg[r].volt_choose;
                    end else if (addr_i == ADDR_VMAX_A + 9'(r * 16)) begin
                        vmax_next[r] = wdata_i[7:0];
                    end
                end
            end
        end
        // Pin voltage selection follows pin state after each edge
        for (int r = 0; r < 2; r++) begin
            if (cfg_reg[r].hw_volt_on && gpi_edge[cfg_reg[r].hw_volt_src]) begin
                cfg_next[r].volt_choose = gpi[cfg_reg[r].hw_volt_src];
                retarget[r] = 1'b1;
            end
        end
        if (rd_i) begin
            if (addr_i == ADDR_OSC)
                rdata_next = {26'h0, trim_reg};
            else if (addr_i == ADDR_STATUS)
                rdata_next = {2'h0, 15'(stat[1]), 15'(stat[0])};
            else if (addr_i == ADDR_LOCK)
                rdata_next = {31'h0, lock};
            else if (addr_i == ADDR_INPUT0)
                rdata_next = {31'h0, track_on_reg};
            else
                for (int r = 0; r < 2; r++) begin
                    if (addr_i == ADDR_CFG_A + 9'(r * 16))
                        rdata_next = {9'h0, cfg_reg[r]};
                    else if (addr_i == ADDR_VPRI_A + 9'(r * 16))
                        rdata_next = {24'h0, vpri_reg[r]};
                    else if (addr_i == ADDR_VALT_A + 9'(r * 16))
                        rdata_next = {24'h0, valt_reg[r]};
                    else if (addr_i == ADDR_VMAX_A + 9'(r * 16))
                        rdata_next = {24'h0, vmax_reg[r]};
                end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int r = 0; r < 2; r++) begin
                cfg_reg[r]  <= '0;
                vpri_reg[r] <= VOLT_RESET;
                valt_reg[r] <= VOLT_RESET;
                vmax_reg[r] <= VMAX_RESET;
            end
            trim_reg     <= TRIM_RESET;
            track_on_reg <= 1'b0;
            rdata_reg    <= 32'h0000_0000;
        end else begin
            cfg_reg      <= cfg_next;
            vpri_reg     <= vpri_next;
            valt_reg     <= valt_next;
            vmax_reg     <= vmax_next;
            trim_reg     <= trim_next;
            track_on_reg <= track_on_next;
            rdata_reg    <= rdata_next;
        end
    end

    assign rdata_o         = rdata_reg;
    assign osc_freq_trim_o = trim_reg;

    // =========================================================
    // Per-regulator ramp, mode and over-current logic
    // =========================================================
    ramp_state_type st_reg [2], st_next [2];
    logic [7:0] vnow_reg [2], vnow_next [2], tick_reg [2], tick_next [2];
    logic [7:0] ocm_reg [2], ocm_next [2], target [2], tick_max [2];
    logic [1:0] busy_reg, busy_next, oc_reg, oc_next, lim_prev_reg, en, pfm;
    logic       in0_reg, in0_next;

    always_comb begin
        for (int r = 0; r < 2; r++) begin
            en[r] = cfg_reg[r].hw_enable_on
                  ? gpi[cfg_reg[r].hw_enable_src] : cfg_reg[r].sw_enable;
            target[r] = clamp_volt(cfg_reg[r].volt_choose
                      ? valt_reg[r] : vpri_reg[r], vmax_reg[r]);
            case (op_mode_type'(cfg_reg[r].op_mode_sel))
                MODE_BY_VOLT: pfm[r] = cfg_reg[r].volt_choose
                                     ? cfg_reg[r].alt_pfm : cfg_reg[r].pri_pfm;
                MODE_PFM:     pfm[r] = 1'b1;
                MODE_PWM:     pfm[r] = 1'b0;
                default:      pfm[r] = !hi_load[r];
            endcase
        end
        if (track_on_reg)
            target[0] = clamp_volt(track_v, vmax_reg[0]);
        for (int r = 0; r < 2; r++)
            tick_max[r] = (st_reg[r] == RS_UP)
                        ? step_cycles(cfg_reg[r].rampup_rate)
                        : step_cycles(cfg_reg[r].slew_rate);
    end

    always_comb begin
        in0_next = gpi_edge[0] && !track_on_reg;
        for (int r = 0; r < 2; r++) begin
            st_next[r]   = st_reg[r];
            vnow_next[r] = vnow_reg[r];
            tick_next[r] = tick_reg[r];
            ocm_next[r]  = ocm_reg[r];
            busy_next[r] = busy_reg[r];
            oc_next[r]   = 1'b0;
            if (tick_reg[r] + 8'h01 >= tick_max[r])
                tick_next[r] = 8'h00;
            else
                tick_next[r] = tick_reg[r] + 8'h01;
            case (st_reg[r])
                RS_OFF: begin
                    vnow_next[r] = 8'h00;
                    busy_next[r] = 1'b0;
                    if (en[r]) begin
                        st_next[r]   = RS_UP;
                        busy_next[r] = 1'b1;
                        tick_next[r] = 8'h00;
                    end
                end
                RS_UP, RS_ON: begin
                    if (!en[r]) begin
                        st_next[r]   = (cfg_reg[r].rampdown_sel != 2'b00)
                                     ? RS_DOWN : RS_OFF;
                        busy_next[r] = 1'b1;
                    end else if (vnow_reg[r] != target[r]) begin
                        busy_next[r] = 1'b1;
                        if (tick_reg[r] == 8'h00)
                            vnow_next[r] = (vnow_reg[r] < target[r])
                                ? vnow_reg[r] + 8'h01
                                : vnow_reg[r] - 8'h01;
                    end else begin
                        st_next[r]   = RS_ON;
                        busy_next[r] = retarget[r];
                    end
                end
                default: begin
                    busy_next[r] = 1'b1;
                    if (en[r])
                        st_next[r] = RS_UP;
                    else if (vnow_reg[r] == 8'h00)
                        st_next[r] = RS_OFF;
                    else if (tick_reg[r] == 8'h00)
                        vnow_next[r] = vnow_reg[r] - 8'h01;
                end
            endcase
            if (busy_reg[r])
                ocm_next[r] = 8'(OC_EXTRA_CYC);
            else if (ocm_reg[r] != 8'h00)
                ocm_next[r] = ocm_reg[r] - 8'h01;
            if (lim_hit[r] && !lim_prev_reg[r] && st_reg[r] != RS_OFF
                && !(cfg_reg[r].overcurrent_mask
                     && (busy_reg[r] || ocm_reg[r] != 8'h00)))
                oc_next[r] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int r = 0; r < 2; r++) begin
                st_reg[r]   <= RS_OFF;
                vnow_reg[r] <= 8'h00;
                tick_reg[r] <= 8'h00;
                ocm_reg[r]  <= 8'h00;
            end
            busy_reg     <= 2'b00;
            lim_prev_reg <= 2'b00;
            oc_reg       <= 2'b00;
            in0_reg      <= 1'b0;
        end else begin
            st_reg       <= st_next;
            vnow_reg     <= vnow_next;
            tick_reg     <= tick_next;
            ocm_reg      <= ocm_next;
            busy_reg     <= busy_next;
            lim_prev_reg <= lim_hit;
            oc_reg       <= oc_next;
            in0_reg      <= in0_next;
        end
    end

    // Ready means the digital ramp is done, nothing about the output
    always_comb begin
        for (int r = 0; r < 2; r++) begin
            stat[r].enabled     = (st_reg[r] != RS_OFF);
            stat[r].ready       = !busy_reg[r];
            stat[r].pfm_active  = pfm[r] && !busy_reg[r];
            stat[r].pulldown_on = (st_reg[r] == RS_OFF)
                                && !cfg_reg[r].pulldown_off;
            stat[r].phases      = (st_reg[r] == RS_OFF) ? 3'h0
                : phase_count(cfg_reg[r].shed_enable && !pfm[r],
                              hi_load[r], cfg_reg[r].max_phases);
            stat[r].volt_now    = vnow_reg[r];
        end
    end

    assign stat_a_o            = stat[0];
    assign stat_b_o            = stat[1];
    assign overcurrent_event_o = oc_reg;
    assign input0_change_o     = in0_reg;

    // =========================================================
    // Assertions
    // =========================================================
    lock_refuse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        wr_i && lock && addr_i == ADDR_VPRI_A |=> $stable(vpri_reg[0]))
        else $error("protected write changed primary voltage");
    ceiling_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        vnow_reg[0] > $past(vnow_reg[0])
        |-> vnow_reg[0] <= $past(vmax_reg[0]))
        else $error("voltage above ceiling");
    phase_cap_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        stat[0].phases <= 3'(cfg_reg[0].max_phases) + 3'h1)
        else $error("phase count above cap");
    track_event_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        track_on_reg |=> !input0_change_o)
        else $error("input 0 event while tracking");
    oc_mask_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg_reg[0].overcurrent_mask && busy_reg[0] |=> !oc_reg[0])
        else $error("over-current event during masked ramp");
    ramp_step_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        st_reg[0] == RS_ON && $changed(vnow_reg[0]) |-> busy_reg[0])
        else $error("voltage moved without ramp flag");

endmodule // buck_voltage_phase_control

`default_nettype wire

// File: pkg/buck_ctrl_pkg.sv
// Constants, types and register map for the buck voltage and phase control
// Assumes a 25 MHz control clock and a simple strobe register port
package buck_ctrl_pkg;

    // Clock and ramp timing
    localparam int CLK_MHZ        = 25;
    localparam int STEP_NS_SLOW   = 4000;
    localparam int STEP_NS_FAST   = 500;
    localparam int STEP_CYC_FAST  = (STEP_NS_FAST * CLK_MHZ) / 1000;
    localparam int OC_EXTRA_NS    = 1000;
    localparam int OC_EXTRA_CYC   = (OC_EXTRA_NS * CLK_MHZ) / 1000;

    // Oscillator trim figures in kHz
    localparam int OSC_BASE_KHZ   = 6000;
    localparam int OSC_STEP_KHZ   = 180;
    localparam int SW_STEP_KHZ    = 90;

    // Register byte offsets
    localparam logic [8:0] ADDR_OSC     = 9'h000;
    localparam logic [8:0] ADDR_STATUS  = 9'h004;
    localparam logic [8:0] ADDR_LOCK    = 9'h008;
    localparam logic [8:0] ADDR_PROT_LO = 9'h0D0;
    localparam logic [8:0] ADDR_PROT_HI = 9'h14F;
    localparam logic [8:0] ADDR_CFG_A   = 9'h0D0;
    localparam logic [8:0] ADDR_VPRI_A  = 9'h0D4;
    localparam logic [8:0] ADDR_VALT_A  = 9'h0D8;
    localparam logic [8:0] ADDR_VMAX_A  = 9'h0DC;
    localparam logic [8:0] ADDR_CFG_B   = 9'h0E0;
    localparam logic [8:0] ADDR_VPRI_B  = 9'h0E4;
    localparam logic [8:0] ADDR_VALT_B  = 9'h0E8;
    localparam logic [8:0] ADDR_VMAX_B  = 9'h0EC;
    localparam logic [8:0] ADDR_INPUT0  = 9'h0F0;

    // Reset values
    localparam logic [7:0] VOLT_RESET   = 8'h46;
    localparam logic [7:0] VMAX_RESET   = 8'h7F;
    localparam logic [5:0] TRIM_RESET   = 6'h20;

    // Operating mode field
    typedef enum logic [1:0] {
        MODE_BY_VOLT = 2'b00,
        MODE_PFM     = 2'b01,
        MODE_PWM     = 2'b10,
        MODE_AUTO    = 2'b11
    } op_mode_type;

    // Per-regulator configuration word
    typedef struct packed {
        logic [1:0] rampup_rate;
        logic [1:0] rampdown_sel;
        logic       pulldown_off;
        logic       overcurrent_mask;
        logic [1:0] hw_enable_src;
        logic       hw_enable_on;
        logic [1:0] hw_volt_src;
        logic       hw_volt_on;
        logic [1:0] max_phases;
        logic       shed_enable;
        logic       volt_choose;
        logic       sw_enable;
        logic       alt_pfm;
        logic       pri_pfm;
        logic [1:0] slew_rate;
        logic [1:0] op_mode_sel;
    } reg_cfg_type;

    // Regulator status toward software and pins
    typedef struct packed {
        logic       enabled;
        logic       ready;
        logic       pfm_active;
        logic       pulldown_on;
        logic [2:0] phases;
        logic [7:0] volt_now;
    } reg_stat_type;

    typedef enum logic [1:0] {
        RS_OFF  = 2'b00,
        RS_UP   = 2'b01,
        RS_ON   = 2'b10,
        RS_DOWN = 2'b11
    } ramp_state_type;

endpackage

// File: verif/buck_voltage_phase_control_tb_top.sv
// Bench for buck voltage and phase control: register port, pins, status
// Assumes pin_model on the far side and a 25 MHz clock
`timescale 1ns/1ns
`default_nettype none
module buck_voltage_phase_control_tb_top;
    import buck_ctrl_pkg::*;
    logic         clk = 1'b0;
    logic         rst_n, wr, rd, lock_cmd, lock, chg, ld;
    logic [8:0]   addr;
    logic [31:0]  wdata, rdata;
    logic [3:0]   gpi_cmd, gpi;
    logic [7:0]   track_cmd, track, v1, vmax, valt, tv;
    logic [1:0]   load_cmd, load, limit_cmd, limit, oc_ev;
    logic [5:0]   trim;
    reg_stat_type stat_a, stat_b;
    reg_cfg_type  cfg;
    int           error_cnt, samples_checked, oc_n, chg_n, n0;
    int unsigned  seed;
    pin_model pins_u (.clk_i(clk), .lock_cmd_i(lock_cmd), .gpi_cmd_i(gpi_cmd),
        .track_cmd_i(track_cmd), .load_cmd_i(load_cmd), .limit_cmd_i(limit_cmd),
        .volt_lock_o(lock), .general_input_o(gpi), .track_volt_o(track),
        .high_load_o(load), .current_limit_o(limit));
    buck_voltage_phase_control #(.MAX_PHASES(4), .GPI_COUNT(4)) dut_u (
        .ref_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .volt_lock_i(lock),
        .general_input_i(gpi), .track_volt_i(track), .high_load_i(load),
        .current_limit_i(limit), .osc_freq_trim_o(trim), .stat_a_o(stat_a),
        .stat_b_o(stat_b), .overcurrent_event_o(oc_ev), .input0_change_o(chg));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        oc_n += int'(oc_ev[0] === 1'b1);
        chg_n += int'(chg === 1'b1);
    end
    // ==========
    // Tasks and expectations
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_check(input logic [8:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask
    task automatic wr_cfg();
        wr_reg(ADDR_CFG_A, {9'h000, cfg});
        repeat (8) @(negedge clk);
    endtask
    task automatic wait_volt(input logic [7:0] exp);
        int n;
        n = 0;
        while (stat_a.volt_now !== exp && n < 4000) begin
            @(negedge clk);
            n++;
        end
        check({24'h0, stat_a.volt_now}, {24'h0, exp});
        if (n >= 4000) begin
            error_cnt++;
            print_verdict();
        end
    endtask
    function automatic logic exp_pfm(input logic [1:0] m, input logic p,
                                     input logic l);
        case (m)
            2'h0: return p;
            2'h1: return 1'b1;
            2'h2: return 1'b0;
            default: return ~l;
        endcase
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ==========
    // Main sequence
    initial begin
        {rst_n, wr, rd, lock_cmd, gpi_cmd, track_cmd, load_cmd, limit_cmd} = '0;
        {addr, wdata, error_cnt, samples_checked, oc_n, chg_n} = '0;
        seed = $urandom(32'h8A3A503F);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd_check(ADDR_OSC, {26'h0, TRIM_RESET});
        rd_check(ADDR_VMAX_A, {24'h0, VMAX_RESET});
        rd_check(ADDR_VPRI_A, {24'h0, VOLT_RESET});
        rd_check(9'h1F0, 32'h0);
        rd_check(ADDR_STATUS, 32'h1400_2800);
        check({17'h0, stat_b}, 32'h0000_2800);
        tv = 8'($urandom_range(63));
        wr_reg(ADDR_OSC, {24'h0, tv});
        #1 check({26'h0, trim}, {24'h0, tv});
        v1 = 8'h40 + 8'($urandom_range(63));
        wr_reg(ADDR_VPRI_A, {24'h0, v1});
        lock_cmd <= 1'b1;
        repeat (8) @(posedge clk);
        wr_reg(ADDR_VPRI_A, 32'h11);
        rd_check(ADDR_VPRI_A, {24'h0, v1});
        wr_reg(ADDR_OSC, 32'h5);
        rd_check(ADDR_OSC, 32'h5);
        lock_cmd <= 1'b0;
        repeat (8) @(posedge clk);
        vmax = 8'h20 + 8'($urandom_range(31));
        valt = 8'h08 + 8'($urandom_range(15));
        wr_reg(ADDR_VMAX_A, {24'h0, vmax});
        wr_reg(ADDR_VALT_A, {24'h0, valt});
        cfg = '0;
        cfg.sw_enable = 1'b1;
        cfg.rampup_rate = 2'h3;
        cfg.slew_rate = 2'h3;
        cfg.op_mode_sel = 2'h2;
        wr_cfg();
        wait_volt(vmax);
        cfg.volt_choose = 1'b1;
        cfg.overcurrent_mask = 1'b1;
        n0 = oc_n;
        wr_reg(ADDR_CFG_A, {9'h000, cfg});
        limit_cmd <= 2'h1;
        repeat (4) @(posedge clk);
        limit_cmd <= 2'h0;
        wait_volt(valt);
        limit_cmd <= 2'h1;
        repeat (8) @(posedge clk);
        limit_cmd <= 2'h0;
        check(oc_n, n0);
        cfg.overcurrent_mask = 1'b0;
        wr_cfg();
        repeat (30) @(posedge clk);
        limit_cmd <= 2'h1;
        repeat (8) @(posedge clk);
        limit_cmd <= 2'h0;
        check(oc_n, n0 + 1);
        for (int i = 0; i < 8; i++) begin
            cfg.op_mode_sel = i[1:0];
            cfg.alt_pfm = 1'($urandom);
            ld = 1'($urandom);
            load_cmd <= {1'b0, ld};
            wr_cfg();
            check(stat_a.pfm_active, exp_pfm(i[1:0], cfg.alt_pfm, ld));
        end
        cfg.op_mode_sel = 2'h2;
        for (int i = 0; i < 8; i++) begin
            cfg.max_phases = i[1:0];
            cfg.shed_enable = i[2];
            ld = 1'($urandom);
            load_cmd <= {1'b0, ld};
            wr_cfg();
            check(stat_a.phases, (i[2] && !ld) ? 3'h1 : {1'b0, i[1:0]} + 3'h1);
        end
        n0 = chg_n;
        gpi_cmd[0] <= 1'b1;
        repeat (8) @(posedge clk);
        check(chg_n, n0 + 1);
        wr_reg(ADDR_VMAX_A, 32'h7F);
        tv = 8'($urandom_range(31));
        track_cmd <= tv;
        wr_reg(ADDR_INPUT0, 32'h1);
        n0 = chg_n;
        gpi_cmd[0] <= 1'b0;
        wait_volt(tv);
        check(chg_n, n0);
        wr_reg(ADDR_INPUT0, 32'h0);
        wait_volt(valt);
        cfg.volt_choose = 1'b0;
        cfg.hw_volt_on = 1'b1;
        cfg.hw_volt_src = 2'h2;
        wr_cfg();
        wait_volt(v1);
        gpi_cmd[2] <= 1'b1;
        wait_volt(valt);
        gpi_cmd[2] <= 1'b0;
        wait_volt(v1);
        cfg.sw_enable = 1'b0;
        cfg.hw_enable_on = 1'b1;
        cfg.hw_enable_src = 2'h1;
        gpi_cmd[1] <= 1'b1;
        repeat (8) @(posedge clk);
        wr_cfg();
        check(stat_a.enabled, 1'b1);
        gpi_cmd[1] <= 1'b0;
        repeat (8) @(negedge clk);
        check({stat_a.enabled, stat_a.pulldown_on}, 2'h1);
        cfg.pulldown_off = 1'b1;
        wr_cfg();
        check(stat_a.pulldown_on, 1'b0);
        print_verdict();
    end
endmodule // buck_voltage_phase_control_tb_top
`default_nettype wire

// File: verif/pin_model.sv
// Far-side pin driver: lock, general inputs, tracking value, load, limit
// Assumes bench commands; pins change only just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module pin_model (
    // Clock
    input  wire logic       clk_i,
    // Commands from the bench
    input  wire logic       lock_cmd_i,
    input  wire logic [3:0] gpi_cmd_i,
    input  wire logic [7:0] track_cmd_i,
    input  wire logic [1:0] load_cmd_i,
    input  wire logic [1:0] limit_cmd_i,
    // Pins toward the block
    output logic            volt_lock_o,
    output logic      [3:0] general_input_o,
    output logic      [7:0] track_volt_o,
    output logic      [1:0] high_load_o,
    output logic      [1:0] current_limit_o
);
    // ==========
    // Pin drive
    initial begin
        {volt_lock_o, general_input_o, track_volt_o} = '0;
        {high_load_o, current_limit_o} = '0;
    end
    always @(posedge clk_i) begin
        volt_lock_o     <= lock_cmd_i;
        general_input_o <= gpi_cmd_i;
        track_volt_o    <= track_cmd_i;
        high_load_o     <= load_cmd_i;
        current_limit_o <= limit_cmd_i;
    end
endmodule // pin_model
`default_nettype wire
